// File: include/wwdt_pkg.sv
// wwdt_pkg: constants, register map and state codes of the windowed watchdog
// assumes: 32-bit apb with 12-bit byte address, option byte sampled at reset release
package wwdt_pkg;

  // apb register byte offsets
  localparam logic [11:0] OFF_KEY    = 12'h000;
  localparam logic [11:0] OFF_CAUSE  = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;

  // restart key values
  localparam logic [7:0] KEY_VALID   = 8'hac;
  localparam logic [7:0] KEY_RST_ON  = 8'h9a;
  localparam logic [7:0] KEY_RST_OFF = 8'h1a;

  // option byte fields
  localparam int OPT_IRQ_BIT = 7;
  localparam int OPT_WIN_HI  = 6;
  localparam int OPT_WIN_LO  = 5;
  localparam int OPT_EN_BIT  = 4;
  localparam int OPT_SEL_HI  = 3;
  localparam int OPT_SEL_LO  = 1;
  localparam int OPT_SB_BIT  = 0;

  // reset cause register
  localparam int          CAUSE_WDT_BIT = 4;
  localparam logic [31:0] CAUSE_RST     = 32'h0000_0000;

  // status register fields
  localparam int ST_CNT_LSB   = 0;
  localparam int ST_WIN_BIT   = 17;
  localparam int ST_RUN_BIT   = 18;
  localparam int ST_FIRST_BIT = 19;
  localparam int ST_OPT_LSB   = 24;

  // counter widths
  localparam int CNT_W = 17;
  localparam int LIM_W = 18;

  // overflow exponents, entry n for select code n
  localparam logic [39:0] OVF_EXP_TABLE = {5'h11, 5'h0f, 5'h0e, 5'h0c,
                                           5'h0a, 5'h09, 5'h08, 5'h07};
  localparam int          OVF_EXP_W     = 5;

  // window open period codes
  localparam logic [1:0] WIN_PROHIB = 2'h0;
  localparam logic [1:0] WIN_50     = 2'h1;
  localparam logic [1:0] WIN_75     = 2'h2;
  localparam logic [1:0] WIN_100    = 2'h3;

  // pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // control states
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_OFF  = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b011,
    ST_TRIP = 3'b100
  } wwdt_state_e;

endpackage : wwdt_pkg

// File: include/wwdt_tim_if.sv
// wwdt_tim_if: latched option fields out, decoded count limits back
// assumes: driven by the watchdog core, decoded by wwdt_limit
interface wwdt_tim_if;
  logic [2:0]               ovf_sel;
  logic [1:0]               win_sel;
  logic                     sb_run;
  logic [wwdt_pkg::LIM_W-1:0] limit;
  logic [wwdt_pkg::LIM_W-1:0] close_lim;
  logic [wwdt_pkg::LIM_W-1:0] irq_pt;

  modport dec (
    input  ovf_sel,
    input  win_sel,
    input  sb_run,
    output limit,
    output close_lim,
    output irq_pt
  );

  modport core (
    output ovf_sel,
    output win_sel,
    output sb_run,
    input  limit,
    input  close_lim,
    input  irq_pt
  );
endinterface : wwdt_tim_if

// File: rtl/wwdt_sync.sv
// wwdt_sync: three-stage synchroniser with rising edge detect
// assumes: async_in may change at any time relative to ref_clk
module wwdt_sync (
  // clock, reset, enable
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // pin side
  input  wire logic async_in,
  // synchronised side
  output logic      level,
  output logic      rise
);

  logic [wwdt_pkg::SYNC_STAGES-1:0] sync_q;
  logic                             level_q;
  logic                             agree;

  // stage 0 feeds stage 1 only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= '0;
    end else if (ce) begin
      sync_q <= {sync_q[wwdt_pkg::SYNC_STAGES-2:0], async_in};
    end
  end

  // a change counts once stages one and two agree
  assign agree = sync_q[2] == sync_q[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (ce && agree) begin
      level_q <= sync_q[2];
    end
  end

  assign level = level_q;
  assign rise  = agree & sync_q[2] & ~level_q;

endmodule : wwdt_sync

// File: rtl/wwdt_limit.sv
// wwdt_limit: decodes overflow select and window select into count limits
// assumes: fields are stable, latched once by the core
module wwdt_limit (
  // option fields in, limits out
  wwdt_tim_if.dec tim
);

  logic [wwdt_pkg::OVF_EXP_W-1:0] exp_v;
  logic [wwdt_pkg::LIM_W-1:0]     lim_v;

  always_comb begin
    exp_v     = wwdt_pkg::OVF_EXP_TABLE[tim.ovf_sel*wwdt_pkg::OVF_EXP_W +: wwdt_pkg::OVF_EXP_W];
    lim_v     = wwdt_pkg::LIM_W'(1) << exp_v;
    tim.limit = lim_v;
    tim.irq_pt = lim_v - (lim_v >> 2);
    case (tim.win_sel)
      wwdt_pkg::WIN_50:  tim.close_lim = lim_v >> 1;
      wwdt_pkg::WIN_75:  tim.close_lim = lim_v >> 2;
      wwdt_pkg::WIN_100: tim.close_lim = '0;
      default:           tim.close_lim = '0;
    endcase
    if (!tim.sb_run) begin
      tim.close_lim = '0;
    end
  end

endmodule : wwdt_limit

// File: rtl/wwdt_top.sv
// wwdt_top: windowed watchdog with apb restart-key access
// assumes: lsosc_clk is the low-speed oscillator pin, slow against ref_clk;
// opt_byte holds steady around reset release; wdt_rst_req goes to a reset controller
//
// Contract
// - key reads 1AH disabled, 9AH enabled
// - wrong key byte trips internal reset
// - bit manipulation on key trips reset
// - key reads return reset value only
// - enable bit picks run or stopped
// - valid key clears and restarts counter
// - later writes in closed window trip
// - first write clears in any phase
// - overflow before key trips reset
// - three bits select overflow length
// - two bits select open tail fraction
// - standby-run zero forces full window
// - standby stops count unless standby-run
// - standby release clears then resumes
// - interval interrupt at three quarters
// - interrupt leaves counter running
// - no pause during flash routines
// - restart skew within two ticks
// - key on last count still saves
// - counts low-speed oscillator edges
// - watchdog reset sets cause bit
module wwdt_top (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // low-speed oscillator pin
  input  wire logic        lsosc_clk,
  // option byte and cpu sideband
  input  wire logic [7:0]  opt_byte,
  input  wire logic        standby,
  input  wire logic        bit_manip,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // events out
  output logic             wdt_rst_req,
  output logic             interval_irq
);

  wwdt_pkg::wwdt_state_e state_q;
  wwdt_pkg::wwdt_state_e state_d;

  logic [7:0]                 opt_q;
  logic [7:0]                 key_q;
  logic [wwdt_pkg::CNT_W-1:0] cnt_q;
  logic [wwdt_pkg::LIM_W-1:0] cnt_inc;
  logic                       first_done_q;
  logic                       cause_q;
  logic                       rst_req_q;
  logic                       irq_q;
  logic [31:0]                prdata_q;
  logic                       pslverr_q;

  logic tick;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic key_wr;
  logic key_bad;
  logic key_late;
  logic key_ok;
  logic active;
  logic win_closed;
  logic ovf;
  logic trip;
  logic cnt_clr;
  logic cnt_step;
  logic hold_release;
  logic [31:0] rd_mux;

  wwdt_tim_if tim ();

  wwdt_sync u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in (lsosc_clk),
    .level    (),
    .rise     (tick)
  );

  wwdt_limit u_limit (
    .tim (tim)
  );

  assign tim.ovf_sel = opt_q[wwdt_pkg::OPT_SEL_HI:wwdt_pkg::OPT_SEL_LO];
  assign tim.win_sel = opt_q[wwdt_pkg::OPT_WIN_HI:wwdt_pkg::OPT_WIN_LO];
  assign tim.sb_run  = opt_q[wwdt_pkg::OPT_SB_BIT];

  // bus decode
  always_comb begin
    setup   = psel & ~penable;
    wr_acc  = ce & psel & penable & pwrite;
    rd_acc  = ce & psel & penable & ~pwrite;
    addr_ok = (paddr == wwdt_pkg::OFF_KEY) || (paddr == wwdt_pkg::OFF_CAUSE) ||
              (paddr == wwdt_pkg::OFF_STATUS);
    key_wr  = wr_acc & (paddr == wwdt_pkg::OFF_KEY) & pstrb[0];
  end

  // key checks and counter events
  always_comb begin
    active     = (state_q == wwdt_pkg::ST_RUN) || (state_q == wwdt_pkg::ST_HOLD);
    win_closed = {1'b0, cnt_q} < tim.close_lim;
    cnt_inc    = {1'b0, cnt_q} + wwdt_pkg::LIM_W'(1);
    key_bad    = key_wr & (bit_manip | (pwdata[7:0] != wwdt_pkg::KEY_VALID));
    key_late   = key_wr & ~key_bad & active & first_done_q & win_closed;
    key_ok     = key_wr & ~key_bad & active & ~key_late;
    ovf        = (state_q == wwdt_pkg::ST_RUN) & tick & (cnt_inc == tim.limit) & ~key_ok;
    trip       = ce & (key_bad | key_late | ovf) &
                 (state_q != wwdt_pkg::ST_TRIP) & (state_q != wwdt_pkg::ST_LOAD);
    hold_release = (state_q == wwdt_pkg::ST_HOLD) & ~standby;
    cnt_clr    = key_ok | hold_release;
    // count only in run, no other pause
    cnt_step   = (state_q == wwdt_pkg::ST_RUN) & tick;
  end

  // control state
  always_comb begin
    state_d = state_q;
    case (state_q)
      wwdt_pkg::ST_LOAD: begin
        if (opt_byte[wwdt_pkg::OPT_EN_BIT]) begin
          state_d = wwdt_pkg::ST_RUN;
        end else begin
          state_d = wwdt_pkg::ST_OFF;
        end
      end
      wwdt_pkg::ST_OFF: begin
        if (trip) begin
          state_d = wwdt_pkg::ST_TRIP;
        end
      end
      wwdt_pkg::ST_RUN: begin
        if (trip) begin
          state_d = wwdt_pkg::ST_TRIP;
        end else if (standby && !tim.sb_run) begin
          state_d = wwdt_pkg::ST_HOLD;
        end
      end
      wwdt_pkg::ST_HOLD: begin
        if (trip) begin
          state_d = wwdt_pkg::ST_TRIP;
        end else if (hold_release) begin
          state_d = wwdt_pkg::ST_RUN;
        end
      end
      wwdt_pkg::ST_TRIP: begin
        state_d = wwdt_pkg::ST_TRIP;
      end
      default: begin
        state_d = wwdt_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= wwdt_pkg::ST_LOAD;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_q <= 8'h00;
    end else if (ce && state_q == wwdt_pkg::ST_LOAD) begin
      opt_q <= opt_byte;
    end
  end

  // key reset value from enable bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= wwdt_pkg::KEY_RST_OFF;
    end else if (ce && state_q == wwdt_pkg::ST_LOAD) begin
      key_q <= opt_byte[wwdt_pkg::OPT_EN_BIT] ? wwdt_pkg::KEY_RST_ON : wwdt_pkg::KEY_RST_OFF;
    end
  end

  // first accepted write opens window checking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_done_q <= 1'b0;
    end else if (ce && key_ok) begin
      first_done_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (cnt_clr) begin
        cnt_q <= '0;
      end else if (cnt_step) begin
        cnt_q <= cnt_inc[wwdt_pkg::CNT_W-1:0];
      end
    end
  end

  // interval pulse when a step reaches irq_pt, gated by option bit 7
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= cnt_step & ~cnt_clr & opt_q[wwdt_pkg::OPT_IRQ_BIT] & (cnt_inc == tim.irq_pt);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_req_q <= 1'b0;
    end else if (ce) begin
      rst_req_q <= trip;
    end
  end

  // cause bit, set wins over read clear
  // only a bit already shown to the reader is cleared
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= 1'b0;
    end else if (ce) begin
      if (trip) begin
        cause_q <= 1'b1;
      end else if (rd_acc && paddr == wwdt_pkg::OFF_CAUSE &&
                   prdata_q[wwdt_pkg::CAUSE_WDT_BIT]) begin
        cause_q <= 1'b0;
      end
    end
  end

  // read data mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      wwdt_pkg::OFF_KEY: begin
        rd_mux[7:0] = key_q;
      end
      wwdt_pkg::OFF_CAUSE: begin
        rd_mux = wwdt_pkg::CAUSE_RST;
        rd_mux[wwdt_pkg::CAUSE_WDT_BIT] = cause_q;
      end
      wwdt_pkg::OFF_STATUS: begin
        rd_mux[wwdt_pkg::ST_CNT_LSB +: wwdt_pkg::CNT_W] = cnt_q;
        rd_mux[wwdt_pkg::ST_WIN_BIT]   = ~win_closed;
        rd_mux[wwdt_pkg::ST_RUN_BIT]   = state_q == wwdt_pkg::ST_RUN;
        rd_mux[wwdt_pkg::ST_FIRST_BIT] = first_done_q;
        rd_mux[wwdt_pkg::ST_OPT_LSB +: 8] = opt_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // answer registered in setup, shown in access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce && setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~addr_ok;
    end
  end

  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q & psel & penable;
  assign pready       = ce;
  assign wdt_rst_req  = rst_req_q;
  assign interval_irq = irq_q;

endmodule : wwdt_top

// File: verification/wwdt_top_chk.sv
// wwdt_top_chk: port-level assertions for the watchdog top
// assumes: bound to wwdt_top, one clock, async active-low reset
module wwdt_top_chk (
  // clock, reset, enable
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // options and sideband
  input wire logic [7:0]  opt_byte,
  input wire logic        bit_manip,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // events
  input wire logic        wdt_rst_req,
  input wire logic        interval_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       first_q;
  logic       trip_q;
  logic       cause_q;
  logic [7:0] opt_q;
  logic       acc;
  logic       kw;
  logic       crd;
  assign acc = psel && penable && pready;
  assign kw  = acc && pwrite && paddr == wwdt_pkg::OFF_KEY && pstrb[0];
  assign crd = acc && !pwrite && paddr == wwdt_pkg::OFF_CAUSE;
  // option copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b1;
      opt_q   <= 8'h00;
    end else if (ce && first_q) begin
      first_q <= 1'b0;
      opt_q   <= opt_byte;
    end
  end
  // trip and cause tracking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_q  <= 1'b0;
      cause_q <= 1'b0;
    end else begin
      trip_q  <= trip_q || wdt_rst_req;
      cause_q <= wdt_rst_req || (cause_q && !crd);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  key_read_a: assert property (
    acc && !pwrite && paddr == wwdt_pkg::OFF_KEY && !first_q |-> prdata[7:0] ==
    (opt_q[4] ? wwdt_pkg::KEY_RST_ON : wwdt_pkg::KEY_RST_OFF)) else $error("key read wrong");
  bad_key_a: assert property (
    kw && !first_q && !trip_q && !wdt_rst_req &&
    (bit_manip || pwdata[7:0] != wwdt_pkg::KEY_VALID) |-> ##[1:2] wdt_rst_req)
    else $error("bad key did not trip");
  off_key_a: assert property (
    kw && !first_q && !opt_q[4] && !bit_manip && pwdata[7:0] == wwdt_pkg::KEY_VALID
    |=> !wdt_rst_req [*2]) else $error("key tripped while disabled");
  one_pulse_a: assert property (
    $rose(wdt_rst_req) |=> $fell(wdt_rst_req)) else $error("reset request not a pulse");
  trip_once_a: assert property (
    trip_q |-> !wdt_rst_req) else $error("second reset request");
  irq_pulse_a: assert property (
    interval_irq |=> !interval_irq) else $error("interval irq not a pulse");
  irq_off_a: assert property (
    !first_q && !opt_q[7] |-> !interval_irq) else $error("irq while disabled");
  cause_a: assert property (
    crd && cause_q |-> prdata[wwdt_pkg::CAUSE_WDT_BIT]) else $error("cause bit missing");
  cover property (wdt_rst_req);
  cover property (interval_irq);
  cover property (kw && pwdata[7:0] == wwdt_pkg::KEY_VALID);
endmodule : wwdt_top_chk

bind wwdt_top wwdt_top_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
  .opt_byte(opt_byte), .bit_manip(bit_manip), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .wdt_rst_req(wdt_rst_req), .interval_irq(interval_irq));

// File: verification/tb_windowed_watchdog_timer.sv
// tb_windowed_watchdog_timer: self-checking bench for wwdt_top
// assumes: low-speed clock at ref_clk/8, option byte set per reset
module tb_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] opt;
    logic [7:0] key;
    int         t1;
    int         t2;
    int         t3;
    int         trip;
    int         irq;
  } wwdt_row_s;
  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        standby   = 1'b0;
  logic        bit_manip = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [7:0]  opt_byte  = 8'h00;
  logic [2:0]  ls_cnt    = 3'h0;
  logic        trip_seen = 1'b0;
  logic        irq_seen  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdt_rst_req;
  logic        interval_irq;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  kx;
  int          n_errors  = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  wwdt_row_s   r;
  wwdt_row_s   rows [13] = '{
    '{8'h31, 8'hac, 5, 5, 4, 1, 0}, '{8'h31, 8'hac, 5, 70, 4, 0, 0},
    '{8'h51, 8'hac, 5, 20, 4, 1, 0}, '{8'h51, 8'hac, 5, 40, 4, 0, 0},
    '{8'h30, 8'hac, 5, 5, 4, 0, 0}, '{8'h11, 8'h55, 5, 0, 4, 1, 0},
    '{8'h01, 8'h55, 5, 0, 4, 1, 0}, '{8'h01, 8'hac, 5, 0, 140, 0, 0},
    '{8'h11, 8'hac, 125, 0, 4, 0, 0}, '{8'h11, 8'hac, 0, 0, 140, 1, 0},
    '{8'h13, 8'hac, 0, 0, 140, 0, 0}, '{8'h13, 8'hac, 0, 0, 270, 1, 0},
    '{8'h91, 8'hac, 0, 0, 140, 1, 1}};

  wwdt_top dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .lsosc_clk(ls_cnt[2]),
    .opt_byte(opt_byte), .standby(standby), .bit_manip(bit_manip),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_rst_req(wdt_rst_req), .interval_irq(interval_irq));

  always #20 ref_clk = ~ref_clk;

  // low-speed clock, event capture, timeout
  always @(posedge ref_clk) begin
    ls_cnt <= ls_cnt + 3'h1;
    cyc <= cyc + 1;
    if (wdt_rst_req === 1'b1) trip_seen <= 1'b1;
    if (interval_irq === 1'b1) irq_seen <= 1'b1;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_v

  task automatic chk_f(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t flag %h exp %h", $time, g, e);
    end
  endtask : chk_f

  task automatic rst(input logic [7:0] o);
    rst_n     <= 1'b0;
    opt_byte  <= o;
    standby   <= 1'b0;
    trip_seen <= 1'b0;
    irq_seen  <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask : rst

  task automatic tick(input int n);
    repeat (n * 8) @(posedge ref_clk);
  endtask : tick

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic m);
    @(posedge ref_clk);
    psel      <= 1'b1;
    pwrite    <= w;
    paddr     <= a;
    pwdata    <= {24'h5a5a5a, d};
    bit_manip <= m;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel      <= 1'b0;
    penable   <= 1'b0;
    bit_manip <= 1'b0;
  endtask : apb

  initial begin
    foreach (rows[i]) begin
      r = rows[i];
      kx = r.opt[4] ? wwdt_pkg::KEY_RST_ON : wwdt_pkg::KEY_RST_OFF;
      rst(r.opt);
      apb(1'b0, wwdt_pkg::OFF_KEY, 8'h00, 1'b0);
      chk_v(rd[7:0], kx);
      if (r.t1 != 0) begin
        tick(r.t1);
        apb(1'b1, wwdt_pkg::OFF_KEY, r.key, 1'b0);
      end
      if (r.t2 != 0) begin
        tick(r.t2);
        apb(1'b1, wwdt_pkg::OFF_KEY, wwdt_pkg::KEY_VALID, 1'b0);
      end
      tick(r.t3);
      chk_f(trip_seen, r.trip[0]);
      chk_f(irq_seen, r.irq[0]);
      apb(1'b0, wwdt_pkg::OFF_CAUSE, 8'h00, 1'b0);
      chk_f(rd[wwdt_pkg::CAUSE_WDT_BIT], r.trip[0]);
      apb(1'b0, wwdt_pkg::OFF_KEY, 8'h00, 1'b0);
      chk_v(rd[7:0], kx);
    end
    // bit manipulation on key, unmapped read
    rst(8'h11);
    apb(1'b1, wwdt_pkg::OFF_KEY, wwdt_pkg::KEY_VALID, 1'b1);
    tick(1);
    chk_f(trip_seen, 1'b1);
    apb(1'b0, 12'h00c, 8'h00, 1'b0);
    chk_f(er, 1'b1);
    // standby stop, clear on release
    rst(8'h10);
    apb(1'b0, wwdt_pkg::OFF_STATUS, 8'h00, 1'b0);
    chk_v(rd[wwdt_pkg::ST_OPT_LSB +: 8], 8'h10);
    chk_f(rd[wwdt_pkg::ST_RUN_BIT], 1'b1);
    chk_f(rd[wwdt_pkg::ST_WIN_BIT], 1'b1);
    tick(100);
    standby <= 1'b1;
    tick(100);
    apb(1'b0, wwdt_pkg::OFF_STATUS, 8'h00, 1'b0);
    chk_f(rd[wwdt_pkg::ST_RUN_BIT], 1'b0);
    tick(100);
    standby <= 1'b0;
    tick(100);
    chk_f(trip_seen, 1'b0);
    tick(40);
    chk_f(trip_seen, 1'b1);
    rst(8'h11);
    standby <= 1'b1;
    tick(140);
    chk_f(trip_seen, 1'b1);
    stop_test();
  end
endmodule : tb_windowed_watchdog_timer
